// ==== logic/energy_nv_pkg.sv ====
// Constants and types for the energy counter store and the NV zone check.
// Assumes one 20 MHz clock and an external NV memory with a word port.
//
// Overview of operation
// - Counters of the first set advance only for flow from side_a_bus to side_b_bus.
// - Counters of the second set advance only for flow from side_b_bus to side_a_bus.
// - Only resettable counters may be cleared, from panel or serial; totals only by a counter-zone default load.
// - Every counter is readable by the remote master over the serial register bus.
// - Counters are kept in NV storage and restored at the next power-up.
// - Counters are written to NV only on save events, never per change.
// - A save snapshots all counters at once and writes them as one operation.
// - Entering the stop-and-clear mode triggers a save.
// - Every hour of powered operation triggers a save.
// - Any clear of counters, panel or serial, triggers a save.
// - Fractional sub-counts are saved and restored with the integer parts.
// - A panel clear acts only on resettable counters of the shown page.
// - At power-up every NV zone is checked; invalid zones raise an error code.
// - Code has one bit per zone, calibration 0001 up to text parameters 0080.
// - Several invalid zones report the bitwise union of their bits.
// - While any zone is invalid, normal operation waits for enter plus exit.
// - On enter plus exit, defaults load only into the invalid zones.
// - Without acknowledgement no defaults are written, so the error repeats.
`default_nettype none
package energy_nv_pkg;
   // ======================================================
   // Counter bank
   localparam int NUM_CNT = 8;
   localparam int CNT_W = 32;
   localparam int FRAC_W = 8;
   localparam logic [7:0] FRAC_MAX = 8'h63;
   localparam logic [7:0] RES_MASK = 8'h55;
   localparam logic [7:0] PAGE_AB_MASK = 8'h05;
   localparam logic [7:0] PAGE_BA_MASK = 8'h50;
   localparam logic [1:0] PAGE_AB = 2'h0;
   localparam logic [1:0] PAGE_BA = 2'h1;
   localparam int IDX_REACT_BIT = 1;
   localparam int IDX_B_TO_A_BIT = 2;
   // ======================================================
   // Zones
   localparam logic [7:0] ZONE_CAL = 8'h01;
   localparam logic [7:0] ZONE_MISC = 8'h02;
   localparam logic [7:0] ZONE_CNT = 8'h04;
   localparam logic [7:0] ZONE_PEAK = 8'h08;
   localparam logic [7:0] ZONE_ALT = 8'h10;
   localparam logic [7:0] ZONE_PAR = 8'h20;
   localparam logic [7:0] ZONE_PLC = 8'h40;
   localparam logic [7:0] ZONE_TEXT = 8'h80;
   // ======================================================
   // APB map
   localparam logic [7:0] OFF_CNT0 = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h20;
   localparam logic [7:0] OFF_CLEAR = 8'h24;
   localparam logic [7:0] OFF_SAVES = 8'h28;
   localparam int ST_BLOCKED_BIT = 8;
   localparam int ST_BUSY_BIT = 9;
   localparam int ST_SHOW_BIT = 10;
   // ======================================================
   // NV word port: even word integer part, odd word fraction
   localparam int NV_AW = 5;
   localparam logic [4:0] NV_CNT_BASE = 5'h00;
   localparam logic [3:0] NV_LAST_WORD = 4'hf;
   // ======================================================
   // Timing
   localparam longint CLK_HZ = 20000000;
   localparam longint HOUR_S = 3600;
   localparam logic [36:0] HOUR_CYC_DFLT = 37'(HOUR_S * CLK_HZ);
   typedef enum logic [1:0] {ST_WAIT, ST_LOAD, ST_IDLE, ST_SAVE} main_state_e;
   typedef enum logic [1:0] {Z_WAIT, Z_HOLD, Z_RUN} zone_state_e;
endpackage : energy_nv_pkg
`default_nettype wire

// ==== logic/counter_bank.sv ====
// Eight direction-gated energy counters with fraction sub-counts.
// Assumes energy quantum pulses last one cycle each.
`timescale 1ns/1ps
`default_nettype none
module counter_bank
   import energy_nv_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic count_en,
   input wire logic act_pulse,
   input wire logic act_b_to_a,
   input wire logic react_pulse,
   input wire logic react_b_to_a,
   input wire logic [7:0] clr_mask,
   input wire logic ld_we,
   input wire logic [2:0] ld_idx,
   input wire logic ld_frac_sel,
   input wire logic [31:0] ld_data,
   output logic [NUM_CNT-1:0][CNT_W-1:0] cnt_int,
   output logic [NUM_CNT-1:0][FRAC_W-1:0] cnt_frac
);
   typedef struct packed {
      logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
      logic [NUM_CNT-1:0][FRAC_W-1:0] frac;
   } bank_s;
   bank_s s_r;
   bank_s s_nxt;
   logic [NUM_CNT-1:0] inc;

   for (genvar i = 0; i < NUM_CNT; i++)
   begin : g_inc
      localparam bit IS_REACT = ((i >> IDX_REACT_BIT) & 1) == 1;
      localparam bit IS_BA = ((i >> IDX_B_TO_A_BIT) & 1) == 1;
      assign inc[i] = count_en && (IS_REACT ? (react_pulse && react_b_to_a == IS_BA)
                                           : (act_pulse && act_b_to_a == IS_BA));
   end

   always_comb
   begin
      s_nxt = s_r;
      for (int k = 0; k < NUM_CNT; k++)
      begin
         if (clr_mask[k])
         begin
            s_nxt.cnt[k] = '0;
            s_nxt.frac[k] = '0;
         end
         else if (inc[k])
         begin
            if (s_r.frac[k] == FRAC_MAX)
            begin
               s_nxt.frac[k] = '0;
               s_nxt.cnt[k] = s_r.cnt[k] + 32'h0000_0001;
            end
            else
               s_nxt.frac[k] = s_r.frac[k] + 8'h01;
         end
      end
      if (ld_we)
      begin
         if (ld_frac_sel)
            s_nxt.frac[ld_idx] = ld_data[FRAC_W-1:0];
         else
            s_nxt.cnt[ld_idx] = ld_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign cnt_int = s_r.cnt;
   assign cnt_frac = s_r.frac;
endmodule : counter_bank
`default_nettype wire

// ==== logic/zone_check.sv ====
// Power-up NV zone check, operator acknowledge and default-load request.
// Assumes the NV memory reports per-zone validity once after power-up.
`timescale 1ns/1ps
`default_nettype none
module zone_check
   import energy_nv_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic check_done,
   input wire logic [7:0] zone_ok,
   input wire logic key_enter,
   input wire logic key_exit,
   output logic [7:0] err_code,
   output logic err_show,
   output logic run_en,
   output logic [7:0] dflt_zone
);
   typedef struct packed {
      zone_state_e st;
      logic [7:0] code;
      logic show;
      logic run;
      logic [7:0] dflt;
   } zone_s;
   zone_s s_r;
   zone_s s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.dflt = '0;
      case (s_r.st)
         Z_WAIT:
            if (check_done)
            begin
               s_nxt.code = ~zone_ok;
               s_nxt.show = (zone_ok != 8'hff);
               s_nxt.run = (zone_ok == 8'hff);
               s_nxt.st = (zone_ok == 8'hff) ? Z_RUN : Z_HOLD;
            end
         Z_HOLD:
            if (key_enter && key_exit)
            begin
               s_nxt.dflt = s_r.code;
               s_nxt.code = '0;
               s_nxt.show = 1'b0;
               s_nxt.run = 1'b1;
               s_nxt.st = Z_RUN;
            end
         default:
            s_nxt.run = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_r <= '{st: Z_WAIT, default: '0};
      else
         s_r <= s_nxt;
   end

   assign err_code = s_r.code;
   assign err_show = s_r.show;
   assign run_en = s_r.run;
   assign dflt_zone = s_r.dflt;
endmodule : zone_check
`default_nettype wire

// ==== logic/energy_counter_nv_store_check.sv ====
// Top: APB slave, save scheduling, NV restore and save sequencing.
// Assumes an NV word port that answers each held request with one ack pulse.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module energy_counter_nv_store_check
   import energy_nv_pkg::*;
#(
   parameter logic [36:0] HOUR_CYCLES = HOUR_CYC_DFLT
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic act_pulse,
   input wire logic act_b_to_a,
   input wire logic react_pulse,
   input wire logic react_b_to_a,
   input wire logic mode_stop_clear,
   input wire logic panel_clear,
   input wire logic [1:0] panel_page,
   input wire logic key_enter,
   input wire logic key_exit,
   input wire logic nv_check_done,
   input wire logic [7:0] nv_zone_ok,
   output logic nv_req,
   output logic nv_we,
   output logic [NV_AW-1:0] nv_addr,
   output logic [31:0] nv_wdata,
   input wire logic [31:0] nv_rdata,
   input wire logic nv_ack,
   output logic [7:0] err_code,
   output logic err_show,
   output logic run_en,
   output logic [7:0] dflt_zone
);
   // ======================================================
   // State
   typedef struct packed {
      main_state_e st;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic nv_req;
      logic nv_we;
      logic [NV_AW-1:0] nv_addr;
      logic [31:0] nv_wdata;
      logic [3:0] widx;
      logic [NUM_CNT-1:0][CNT_W-1:0] snap_int;
      logic [NUM_CNT-1:0][FRAC_W-1:0] snap_frac;
      logic save_pend;
      logic [36:0] hour_cnt;
      logic mode_d;
      logic [31:0] saves;
   } top_s;
   top_s s_r;
   top_s s_nxt;

   logic [NUM_CNT-1:0][CNT_W-1:0] cnt_int;
   logic [NUM_CNT-1:0][FRAC_W-1:0] cnt_frac;
   logic [7:0] clr_mask;
   logic [7:0] apb_clr;
   logic [7:0] page_mask;
   logic [31:0] rd_data;
   logic rd_hit;
   logic apb_acc;
   logic apb_done;
   logic count_en;
   logic ld_we;
   logic hour_tick;
   logic mode_rise;
   logic save_trig;
   logic save_start;

   // ======================================================
   // Submodules
   counter_bank u_bank (
      .pclk(pclk),
      .presetn(presetn),
      .count_en(count_en),
      .act_pulse(act_pulse),
      .act_b_to_a(act_b_to_a),
      .react_pulse(react_pulse),
      .react_b_to_a(react_b_to_a),
      .clr_mask(clr_mask),
      .ld_we(ld_we),
      .ld_idx(s_r.widx[3:1]),
      .ld_frac_sel(s_r.widx[0]),
      .ld_data(nv_rdata),
      .cnt_int(cnt_int),
      .cnt_frac(cnt_frac)
   );

   zone_check u_zone (
      .pclk(pclk),
      .presetn(presetn),
      .check_done(nv_check_done),
      .zone_ok(nv_zone_ok),
      .key_enter(key_enter),
      .key_exit(key_exit),
      .err_code(err_code),
      .err_show(err_show),
      .run_en(run_en),
      .dflt_zone(dflt_zone)
   );

   // ======================================================
   // APB decode
   assign apb_acc = psel && penable;
   assign apb_done = apb_acc && s_r.pready;

   always_comb
   begin
      rd_data = '0;
      rd_hit = 1'b1;
      if (paddr[1:0] != 2'b00)
         rd_hit = 1'b0;
      else if (paddr < OFF_STATUS)
         rd_data = cnt_int[paddr[4:2]];
      else if (paddr == OFF_STATUS)
      begin
         rd_data[7:0] = err_code;
         rd_data[ST_BLOCKED_BIT] = !run_en;
         rd_data[ST_BUSY_BIT] = (s_r.st == ST_SAVE);
         rd_data[ST_SHOW_BIT] = err_show;
      end
      else if (paddr == OFF_CLEAR)
         rd_data = '0;
      else if (paddr == OFF_SAVES)
         rd_data = s_r.saves;
      else
         rd_hit = 1'b0;
   end

   // ======================================================
   // Clears: requests never reach totals; only a counter-zone default load clears them
   always_comb
   begin
      apb_clr = '0;
      if (apb_done && pwrite && paddr == OFF_CLEAR)
         apb_clr = pwdata[7:0] & RES_MASK;
   end

   always_comb
   begin
      page_mask = '0;
      if (panel_page == PAGE_AB)
         page_mask = PAGE_AB_MASK;
      else if (panel_page == PAGE_BA)
         page_mask = PAGE_BA_MASK;
   end

   always_comb
   begin
      clr_mask = '0;
      if (run_en)
         clr_mask = apb_clr | (panel_clear ? page_mask : 8'h00);
      if (dflt_zone[2])
         clr_mask = 8'hff;
   end

   // ======================================================
   // Save scheduling
   assign count_en = run_en && (s_r.st != ST_LOAD);
   assign hour_tick = (s_r.hour_cnt == HOUR_CYCLES - 37'h0_0000_0001);
   assign mode_rise = mode_stop_clear && !s_r.mode_d;
   assign save_trig = run_en && (hour_tick || mode_rise || (clr_mask != 8'h00));
   assign save_start = (s_r.st == ST_IDLE) && s_r.save_pend;
   assign ld_we = (s_r.st == ST_LOAD) && nv_ack;

   // ======================================================
   // Next state
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.mode_d = mode_stop_clear;

      // One wait state: pready rises in the second access cycle
      if (apb_acc && !s_r.pready)
      begin
         s_nxt.pready = 1'b1;
         s_nxt.prdata = pwrite ? 32'h0000_0000 : rd_data;
         s_nxt.pslverr = !rd_hit;
      end
      else
      begin
         s_nxt.pready = 1'b0;
         s_nxt.pslverr = 1'b0;
      end

      if (hour_tick)
         s_nxt.hour_cnt = '0;
      else
         s_nxt.hour_cnt = s_r.hour_cnt + 37'h0_0000_0001;

      // A trigger in the cycle the save starts stays pending
      s_nxt.save_pend = (s_r.save_pend && !save_start) || save_trig;

      case (s_r.st)
         ST_WAIT:
            if (nv_check_done)
            begin
               if ((nv_zone_ok & ZONE_CNT) != 8'h00)
               begin
                  s_nxt.st = ST_LOAD;
                  s_nxt.nv_req = 1'b1;
                  s_nxt.nv_we = 1'b0;
                  s_nxt.nv_addr = NV_CNT_BASE;
                  s_nxt.widx = '0;
               end
               else
                  s_nxt.st = ST_IDLE;
            end
         ST_LOAD:
            if (nv_ack)
            begin
               if (s_r.widx == NV_LAST_WORD)
               begin
                  s_nxt.st = ST_IDLE;
                  s_nxt.nv_req = 1'b0;
               end
               else
               begin
                  s_nxt.widx = s_r.widx + 4'h1;
                  s_nxt.nv_addr = NV_CNT_BASE + {1'b0, s_r.widx + 4'h1};
               end
            end
         ST_IDLE:
            if (save_start)
            begin
               s_nxt.snap_int = cnt_int;
               s_nxt.snap_frac = cnt_frac;
               s_nxt.st = ST_SAVE;
               s_nxt.nv_req = 1'b1;
               s_nxt.nv_we = 1'b1;
               s_nxt.nv_addr = NV_CNT_BASE;
               s_nxt.widx = '0;
               s_nxt.nv_wdata = cnt_int[0];
            end
         default:
            if (nv_ack)
            begin
               if (s_r.widx == NV_LAST_WORD)
               begin
                  s_nxt.st = ST_IDLE;
                  s_nxt.nv_req = 1'b0;
                  s_nxt.nv_we = 1'b0;
                  s_nxt.saves = s_r.saves + 32'h0000_0001;
               end
               else
               begin
                  s_nxt.widx = s_r.widx + 4'h1;
                  s_nxt.nv_addr = NV_CNT_BASE + {1'b0, s_r.widx + 4'h1};
                  if (s_r.widx[0])
                     s_nxt.nv_wdata = s_r.snap_int[s_r.widx[3:1] + 3'h1];
                  else
                     s_nxt.nv_wdata = {24'h00_0000, s_r.snap_frac[s_r.widx[3:1]]};
               end
            end
      endcase
   end

   // ======================================================
   // Registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_r <= '{st: ST_WAIT, default: '0};
      else
         s_r <= s_nxt;
   end

   assign pready = s_r.pready;
   assign prdata = s_r.prdata;
   assign pslverr = s_r.pslverr;
   assign nv_req = s_r.nv_req;
   assign nv_we = s_r.nv_we;
   assign nv_addr = s_r.nv_addr;
   assign nv_wdata = s_r.nv_wdata;
endmodule : energy_counter_nv_store_check
`default_nettype wire

// ==== test/nv_mem_model.sv ====
// Word-wide NV memory standing on the far side of the block's NV port.
// Assumes the block holds request, direction, address and data until nv_ack.
`timescale 1ns/1ps
`default_nettype none
module nv_mem_model
(
   input wire logic pclk,
   input wire logic nv_req,
   input wire logic nv_we,
   input wire logic [4:0] nv_addr,
   input wire logic [31:0] nv_wdata,
   input wire logic [1:0] lat,
   output logic [31:0] nv_rdata,
   output logic nv_ack
);
   logic [31:0] mem [16];
   logic [1:0] wait_cnt;
   initial
   begin
      nv_ack = 1'b0;
      nv_rdata = 32'h0000_0000;
      wait_cnt = 2'h0;
   end
   // ======================================================
   // Answer after lat idle cycles, one word per ack
   always @(posedge pclk)
   begin
      nv_ack <= 1'b0;
      // Data not being answered toggles, so a late sample cannot pass
      nv_rdata <= ~nv_rdata;
      if (nv_req && !nv_ack)
      begin
         if (wait_cnt < lat)
            wait_cnt <= wait_cnt + 2'h1;
         else
         begin
            wait_cnt <= 2'h0;
            nv_ack <= 1'b1;
            if (nv_we)
               mem[nv_addr[3:0]] <= nv_wdata;
            else
               nv_rdata <= mem[nv_addr[3:0]];
         end
      end
   end
endmodule : nv_mem_model
`default_nettype wire

// ==== test/energy_counter_nv_store_check_checker.sv ====
// Assertions on APB timing, the zone check and the NV save sequence.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module energy_nv_checker
   import energy_nv_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic mode_stop_clear,
   input wire logic key_enter,
   input wire logic key_exit,
   input wire logic nv_check_done,
   input wire logic [7:0] nv_zone_ok,
   input wire logic nv_req,
   input wire logic nv_we,
   input wire logic [NV_AW-1:0] nv_addr,
   input wire logic nv_ack,
   input wire logic [7:0] err_code,
   input wire logic err_show,
   input wire logic run_en,
   input wire logic [7:0] dflt_zone
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ======================================================
   // Properties
   property p_apb_wait;
      psel && $rose(penable) |=> pready ##1 !pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait)
      else $error("APB answer late or too long");
   property p_code;
      nv_check_done |=> err_code == ~$past(nv_zone_ok);
   endproperty
   a_code: assert property (p_code)
      else $error("zone code is not the union of bad zones");
   property p_show;
      nv_check_done && nv_zone_ok != 8'hff |=> err_show && !run_en;
   endproperty
   a_show: assert property (p_show)
      else $error("bad zone raised no indication");
   property p_clean;
      nv_check_done && nv_zone_ok == 8'hff |=> !err_show && err_code == 8'h00;
   endproperty
   a_clean: assert property (p_clean)
      else $error("indication with all zones good");
   property p_block;
      err_show |-> !run_en && !(nv_req && nv_we);
   endproperty
   a_block: assert property (p_block)
      else $error("operation while a zone is bad");
   property p_ack;
      err_show && key_enter && key_exit |=>
         dflt_zone == $past(err_code) && run_en && err_code == 8'h00 ##1 dflt_zone == 8'h00;
   endproperty
   a_ack: assert property (p_ack)
      else $error("acknowledge did not load defaults");
   property p_no_dflt;
      dflt_zone != 8'h00 |-> $past(key_enter) && $past(key_exit);
   endproperty
   a_no_dflt: assert property (p_no_dflt)
      else $error("defaults without acknowledge");
   property p_save_start;
      $rose(nv_req) |-> nv_addr == 5'h00;
   endproperty
   a_save_start: assert property (p_save_start)
      else $error("NV transfer not from word 0");
   property p_save_hold;
      nv_req && !nv_ack |=> nv_req && $stable(nv_addr);
   endproperty
   a_save_hold: assert property (p_save_hold)
      else $error("NV request dropped or moved early");
   property p_save_end;
      nv_req && nv_ack && nv_addr == 5'h0f |=> !nv_req;
   endproperty
   a_save_end: assert property (p_save_end)
      else $error("NV request held past word 15");
   property p_stop;
      run_en && !nv_req && $rose(mode_stop_clear) |-> ##[1:4] nv_req && nv_we;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop mode started no save");
endmodule : energy_nv_checker
bind energy_counter_nv_store_check energy_nv_checker energy_nv_checker_inst (.pclk, .presetn,
   .psel, .penable, .pready, .mode_stop_clear, .key_enter, .key_exit, .nv_check_done,
   .nv_zone_ok, .nv_req, .nv_we, .nv_addr, .nv_ack, .err_code, .err_show, .run_en, .dflt_zone);
`default_nettype wire

// ==== test/energy_counter_nv_store_check_tb.sv ====
// Self-checking bench for the energy counter store and NV zone check.
// Assumes the NV model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
   $display("[FAIL] %0t got %h, expected %h", $time, (a), (e)); end end
module energy_counter_nv_store_check_tb;
   import energy_nv_pkg::*;
   // Short hour keeps the hourly save inside the run
   localparam logic [36:0] HOURS = 37'h0_0000_1388;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, er;
   logic act_pulse, act_b_to_a, react_pulse, react_b_to_a, mode_stop_clear, panel_clear;
   logic key_enter, key_exit, nv_check_done, nv_req, nv_we, nv_ack, err_show, run_en;
   logic [1:0] panel_page, lat;
   logic [7:0] paddr, nv_zone_ok, err_code, dflt_zone;
   logic [4:0] nv_addr;
   logic [31:0] pwdata, prdata, nv_wdata, nv_rdata, rd, saves;
   logic [31:0] expc [8];
   // Rows: {reactive, b_to_a, first counter index}
   logic [4:0] rows [4] = '{5'h00, 5'h12, 5'h0c, 5'h1e};
   int miscompares = 0;
   int checks = 0;
   int cyc = 0;
   int rel = 0;
   energy_counter_nv_store_check #(.HOUR_CYCLES(HOURS)) energy_counter_nv_store_check_inst (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
      .act_pulse, .act_b_to_a, .react_pulse, .react_b_to_a, .mode_stop_clear, .panel_clear,
      .panel_page, .key_enter, .key_exit, .nv_check_done, .nv_zone_ok, .nv_req, .nv_we,
      .nv_addr, .nv_wdata, .nv_rdata, .nv_ack, .err_code, .err_show, .run_en, .dflt_zone);
   nv_mem_model nv_mem_model_inst (.pclk, .nv_req, .nv_we, .nv_addr, .nv_wdata, .lat,
      .nv_rdata, .nv_ack);
   always #25 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         finish_test();
      end
   end
   // ======================================================
   // Tasks
   task automatic finish_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rdcnt();
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b0, 8'(i * 4), 32'h0000_0000);
         `CHK(rd, expc[i])
      end
   endtask : rdcnt
   // The other kind of flow points the opposite way while one kind pulses
   task automatic pulse(input logic re, input logic ba, input int n);
      act_b_to_a <= ba ^ re;
      react_b_to_a <= ba ^ !re;
      repeat (n)
      begin
         act_pulse <= !re;
         react_pulse <= re;
         @(posedge pclk);
         act_pulse <= 1'b0;
         react_pulse <= 1'b0;
         @(posedge pclk);
      end
   endtask : pulse
   task automatic wsave();
      while (!(nv_req === 1'b1 && nv_we === 1'b1))
         @(posedge pclk);
      while (nv_req === 1'b1)
         @(posedge pclk);
      saves++;
      apb(1'b0, OFF_SAVES, 32'h0000_0000);
      `CHK(rd, saves)
   endtask : wsave
   task automatic power(input logic [7:0] zok);
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      `CHK(run_en, 1'b0)
      presetn <= 1'b1;
      rel = cyc;
      saves = 32'h0000_0000;
      repeat (3) @(posedge pclk);
      nv_zone_ok <= zok;
      nv_check_done <= 1'b1;
      @(posedge pclk);
      nv_check_done <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK(err_code, ~zok)
      `CHK(err_show, zok != 8'hff)
      for (int n = 0; n < 8 && nv_req !== 1'b1; n++)
         @(posedge pclk);
      while (nv_req === 1'b1)
         @(posedge pclk);
   endtask : power
   task automatic ack(input logic [7:0] code);
      key_enter <= 1'b1;
      key_exit <= 1'b1;
      @(posedge pclk);
      key_enter <= 1'b0;
      key_exit <= 1'b0;
      @(posedge pclk);
      `CHK(dflt_zone, code)
      `CHK(run_en, 1'b1)
      `CHK(err_code, 8'h00)
   endtask : ack
   // ======================================================
   // Main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, act_pulse, act_b_to_a, react_pulse} = 7'h00;
      {react_b_to_a, mode_stop_clear, panel_clear, key_enter, key_exit} = 5'h00;
      nv_check_done = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      panel_page = 2'h0;
      nv_zone_ok = 8'hff;
      lat = 2'h1;
      for (int i = 0; i < 8; i++)
      begin
         expc[i] = 32'(i * 16 + 1);
         nv_mem_model_inst.mem[2 * i] = expc[i];
         nv_mem_model_inst.mem[2 * i + 1] = 32'h0000_0000;
      end
      // Counter 0 comes back two quanta short of a carry
      nv_mem_model_inst.mem[1] = 32'h0000_0062;
      power(8'hff);
      `CHK(run_en, 1'b1)
      pulse(1'b0, 1'b0, 2);
      expc[0]++;
      rdcnt();
      for (int r = 0; r < 4; r++)
      begin
         pulse(rows[r][4], rows[r][3], 100);
         expc[rows[r][2:0]]++;
         expc[rows[r][2:0] + 1]++;
         rdcnt();
      end
      apb(1'b0, OFF_SAVES, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      apb(1'b0, 8'h2c, 32'h0000_0000);
      `CHK(er, 1'b1)
      apb(1'b0, 8'h02, 32'h0000_0000);
      `CHK(er, 1'b1)
      for (int p = 0; p < 3; p++)
      begin
         panel_page <= 2'(p);
         panel_clear <= 1'b1;
         @(posedge pclk);
         panel_clear <= 1'b0;
         if (p < 2)
            wsave();
         for (int i = 0; i < 8; i++)
            if (p < 2 && i % 2 == 0 && i / 4 == p)
               expc[i] = 32'h0000_0000;
         rdcnt();
      end
      apb(1'b0, OFF_SAVES, 32'h0000_0000);
      `CHK(rd, saves)
      pulse(1'b0, 1'b0, 100);
      expc[0]++;
      expc[1]++;
      apb(1'b1, OFF_CLEAR, 32'h0000_00ff);
      wsave();
      for (int i = 0; i < 8; i += 2)
         expc[i] = 32'h0000_0000;
      rdcnt();
      for (int i = 0; i < 8; i++)
         `CHK(nv_mem_model_inst.mem[2 * i], expc[i])
      `CHK(nv_mem_model_inst.mem[3], 32'h0000_0002)
      lat = 2'h3;
      mode_stop_clear <= 1'b1;
      wsave();
      mode_stop_clear <= 1'b0;
      while (!(nv_req === 1'b1 && nv_we === 1'b1))
         @(posedge pclk);
      `CHK(cyc - rel >= HOURS && cyc - rel <= HOURS + 6, 1'b1)
      wsave();
      lat = 2'h0;
      power(8'hde);
      pulse(1'b0, 1'b0, 100);
      rdcnt();
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      `CHK(rd, 32'h0000_0521)
      power(8'hde);
      `CHK(err_code, 8'h21)
      ack(8'h21);
      rdcnt();
      power(8'hfb);
      ack(8'h04);
      wsave();
      for (int i = 0; i < 8; i++)
         expc[i] = 32'h0000_0000;
      rdcnt();
      for (int i = 0; i < 8; i++)
         `CHK(nv_mem_model_inst.mem[2 * i], 32'h0000_0000)
      finish_test();
   end
endmodule : energy_counter_nv_store_check_tb
`default_nettype wire
